//--- design/mrs_decode.sv
// Opcode decoder for block push and block pop
`timescale 1ns/10ps
module mrs_decode
  import mrs_pkg::*;
(
  input wire logic [15:0] opcode,
  input wire logic prefix_seen,
  output logic is_push,
  output logic is_pop,
  output logic word_form,
  output logic [CNT_W-1:0] count,
  output logic [IDX_W-1:0] reg_sel,
  output logic is_prefix
);
  // Single-word opcodes, rejected after an extension prefix
  // Prefix words go to the extended move path, which owns the short-move substitution
  assign is_prefix = (opcode & OP_EXT_MASK) == OP_EXT;
  assign is_push = ((opcode & OP_MASK) == OP_PUSH) && !prefix_seen;
  assign is_pop = ((opcode & OP_MASK) == OP_POP) && !prefix_seen;
  assign word_form = opcode[BIT_WORDFORM];
  // Count field holds n-1, so 1..16 all encode
  assign count = {1'b0, opcode[7:4]} + CNT_MIN;
  assign reg_sel = opcode[3:0];
endmodule : mrs_decode

//--- design/mrs_pkg.sv
// Constants and types for the multi-register stack transfer block
package mrs_pkg;
  localparam int REG_W = 20;
  localparam int WORD_W = 16;
  localparam int HI_W = REG_W - WORD_W;
  localparam int IDX_W = 4;
  localparam int CNT_W = 5;
  localparam logic [3:0] SR_IDX = 4'h2;
  localparam logic [REG_W-1:0] STEP_WORD = 20'h00002;
  localparam logic [REG_W-1:0] STEP_ADDR = 20'h00004;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h10;
  localparam logic [CNT_W-1:0] CNT_MIN = 5'h01;
  localparam logic [15:0] OP_MASK = 16'hFE00;
  localparam logic [15:0] OP_PUSH = 16'h1400;
  localparam logic [15:0] OP_POP = 16'h1600;
  localparam logic [15:0] OP_EXT_MASK = 16'hF800;
  localparam logic [15:0] OP_EXT = 16'h1800;
  localparam int BIT_WORDFORM = 8;
  typedef enum logic [2:0] {
    MRS_IDLE = 3'b000,
    MRS_LO = 3'b001,
    MRS_HI = 3'b011,
    MRS_SP = 3'b010,
    MRS_DONE = 3'b110
  } mrs_state_e;
endpackage : mrs_pkg

//--- design/mrs_top.sv
// Multi-register stack transfer sequencer
`timescale 1ns/10ps
module mrs_top
  import mrs_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic op_valid,
  input wire logic [15:0] opcode,
  input wire logic prefix_seen,
  input wire logic [REG_W-1:0] sp_in,
  input wire logic [REG_W-1:0] reg_rdata,
  input wire logic mem_ready,
  input wire logic [WORD_W-1:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [IDX_W-1:0] reg_addr,
  output logic reg_we,
  output logic [REG_W-1:0] reg_wdata,
  output logic sr_loaded,
  output logic sp_we,
  output logic [REG_W-1:0] sp_wdata,
  output logic mem_req,
  output logic mem_we,
  output logic [REG_W-1:0] mem_addr,
  output logic [WORD_W-1:0] mem_wdata
);
  logic rst_s1_q;
  logic rst_s2_q;
  mrs_state_e state_q;
  mrs_state_e state_d;
  logic push_q;
  logic word_q;
  logic [CNT_W-1:0] left_q;
  logic [CNT_W-1:0] total_q;
  logic [IDX_W-1:0] cur_q;
  logic [REG_W-1:0] addr_q;
  logic [REG_W-1:0] sp_q;
  logic [WORD_W-1:0] lo_q;
  logic busy_q;
  logic done_q;
  logic illegal_q;
  logic reg_we_q;
  logic sr_q;
  logic sp_we_q;
  logic [REG_W-1:0] sp_wdata_q;
  logic [REG_W-1:0] reg_wdata_q;
  logic [IDX_W-1:0] reg_addr_q;
  logic mem_req_q;
  logic mem_we_q;
  logic [REG_W-1:0] mem_addr_q;
  logic [WORD_W-1:0] mem_wdata_q;
  logic rst_n;

  // Reset release through two flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  logic d_push;
  logic d_pop;
  logic d_word;
  logic [CNT_W-1:0] d_cnt;
  logic [IDX_W-1:0] d_reg;
  logic d_prefix;
  mrs_decode u_dec (
    .opcode(opcode),
    .prefix_seen(prefix_seen),
    .is_push(d_push),
    .is_pop(d_pop),
    .word_form(d_word),
    .count(d_cnt),
    .reg_sel(d_reg),
    .is_prefix(d_prefix)
  );

  // Start decode and step arithmetic
  wire start = op_valid && (state_q == MRS_IDLE) && (d_push || d_pop);
  wire bad = op_valid && (state_q == MRS_IDLE) && !d_push && !d_pop && !d_prefix;
  wire [IDX_W-1:0] pop_first = d_reg - IDX_W'(d_cnt - CNT_MIN);
  wire [REG_W-1:0] step = word_q ? STEP_WORD : STEP_ADDR;
  wire [REG_W-1:0] tot_bytes = word_q ? REG_W'({total_q, 1'b0}) : REG_W'({total_q, 2'b00});
  wire [REG_W-1:0] push_base = sp_in - (d_word ? STEP_WORD : STEP_ADDR);
  wire last_word = word_q || (state_q == MRS_HI);
  // Push writes low word first at lower address, upper bits above
  wire [WORD_W-1:0] push_lo = reg_rdata[WORD_W-1:0];
  wire [WORD_W-1:0] push_hi = {{(WORD_W-HI_W){1'b0}}, reg_rdata[REG_W-1:WORD_W]};
  // Pop result, upper bits cleared in word form
  wire [REG_W-1:0] pop_val = word_q ? {{HI_W{1'b0}}, mem_rdata}
                                    : {mem_rdata[HI_W-1:0], lo_q};
  wire step_ok = mem_req_q && mem_ready;
  wire finish_reg = step_ok && last_word;
  wire more = left_q != CNT_MIN;
  wire [IDX_W-1:0] next_cur = push_q ? cur_q - 4'h1 : cur_q + 4'h1;
  // Push data follows the registered index through the register file read,
  // so a push waits one cycle after the index moves before it requests memory
  wire push_now = start ? d_push : push_q;
  wire reload = start || finish_reg;

  // State sequence: word accesses, then one pointer update
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MRS_IDLE: begin
        if (start) state_d = MRS_LO;
      end
      MRS_LO: begin
        if (step_ok) state_d = word_q ? (more ? MRS_LO : MRS_SP) : MRS_HI;
      end
      MRS_HI: begin
        if (step_ok) state_d = more ? MRS_LO : MRS_SP;
      end
      MRS_SP: state_d = MRS_DONE;
      MRS_DONE: state_d = MRS_IDLE;
      default: state_d = MRS_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= MRS_IDLE;
      push_q <= 1'b0;
      word_q <= 1'b0;
      left_q <= CNT_MIN;
      total_q <= CNT_MIN;
      cur_q <= '0;
      addr_q <= '0;
      sp_q <= '0;
      lo_q <= '0;
    end else begin
      state_q <= state_d;
      if (start) begin
        push_q <= d_push;
        word_q <= d_word;
        left_q <= d_cnt;
        total_q <= d_cnt;
        cur_q <= d_push ? d_reg : pop_first;
        addr_q <= d_push ? push_base : sp_in;
        sp_q <= sp_in;
      end else if (step_ok) begin
        if (!word_q && state_q == MRS_LO) begin
          lo_q <= mem_rdata;
          addr_q <= addr_q + STEP_WORD;
        end else begin
          left_q <= left_q - CNT_MIN;
          cur_q <= next_cur;
          addr_q <= push_q ? addr_q - step - (word_q ? '0 : STEP_WORD) : addr_q + STEP_WORD;
        end
      end
    end
  end

  // Output registers; only the block's registers (on pop), stack memory (on push) and SP are written
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
      reg_we_q <= 1'b0;
      sr_q <= 1'b0;
      sp_we_q <= 1'b0;
      sp_wdata_q <= '0;
      reg_wdata_q <= '0;
      reg_addr_q <= '0;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= '0;
      mem_wdata_q <= '0;
    end else begin
      busy_q <= state_d != MRS_IDLE;
      done_q <= state_q == MRS_SP;
      illegal_q <= bad;
      reg_we_q <= finish_reg && !push_q;
      sr_q <= finish_reg && !push_q && cur_q == SR_IDX;
      reg_wdata_q <= pop_val;
      sp_we_q <= state_q == MRS_SP;
      sp_wdata_q <= push_q ? sp_q - tot_bytes : sp_q + tot_bytes;
      // Request gap after an index change keeps stale push data off the bus
      mem_req_q <= (state_d == MRS_LO || state_d == MRS_HI) && !(reload && push_now);
      mem_we_q <= (state_d == MRS_LO || state_d == MRS_HI) && push_now;
      if (start) begin
        reg_addr_q <= d_push ? d_reg : pop_first;
        mem_addr_q <= d_push ? push_base : sp_in;
      end else if (step_ok) begin
        // Pop keeps the index of the register written in the next cycle
        reg_addr_q <= (last_word && push_q) ? next_cur : cur_q;
        mem_addr_q <= (!word_q && state_q == MRS_LO) ? addr_q + STEP_WORD
                      : (push_q ? addr_q - step - (word_q ? '0 : STEP_WORD) : addr_q + STEP_WORD);
      end
      mem_wdata_q <= (state_d == MRS_HI) ? push_hi : push_lo;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign illegal = illegal_q;
  assign reg_we = reg_we_q;
  assign reg_wdata = reg_wdata_q;
  assign reg_addr = reg_addr_q;
  assign sr_loaded = sr_q;
  assign sp_we = sp_we_q;
  assign sp_wdata = sp_wdata_q;
  assign mem_req = mem_req_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
endmodule : mrs_top

//--- verification/mrs_mem_model.sv
// Stack memory with random wait states
`timescale 1ns/10ps
module mrs_mem_model (
  input wire logic clock,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [19:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ready,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [logic [19:0]];
  int seed = 11;
  initial {mem_ready, mem_rdata} = 17'h00000;
  // Answer a held request after a random wait, then scramble the data
  always @(negedge clock) begin
    if (mem_ready) begin
      mem_ready <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && $random(seed) % 2 != 0) begin
      mem_ready <= 1'b1;
      if (mem_we) mem[mem_addr] = mem_wdata;
      mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr];
    end
  end
endmodule : mrs_mem_model

//--- verification/mrs_top_assertions.sv
// Property checker for the stack transfer sequencer
`timescale 1ns/10ps
module mrs_top_checker
  import mrs_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic op_valid,
  input wire logic [15:0] opcode,
  input wire logic prefix_seen,
  input wire logic [REG_W-1:0] sp_in,
  input wire logic busy,
  input wire logic done,
  input wire logic [IDX_W-1:0] reg_addr,
  input wire logic reg_we,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic sr_loaded,
  input wire logic sp_we,
  input wire logic [REG_W-1:0] sp_wdata,
  input wire logic mem_req,
  input wire logic mem_we
);
  logic push_q, word_q;
  logic [CNT_W-1:0] n_q;
  logic [REG_W-1:0] sp_q;
  // Expected final pointer
  wire start = op_valid && !busy && !prefix_seen && opcode[15:10] == 6'h05;
  wire [REG_W-1:0] delta = (word_q ? STEP_WORD : STEP_ADDR) * n_q;
  wire [REG_W-1:0] sp_exp = push_q ? sp_q - delta : sp_q + delta;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // Latch the operation taken
  always_ff @(posedge clock) begin
    if (start) begin
      push_q <= !opcode[9];
      word_q <= opcode[8];
      n_q <= {1'b0, opcode[7:4]} + CNT_MIN;
      sp_q <= sp_in;
    end
  end
  property p_take; start |=> busy; endproperty
  a_take: assert property (p_take) else $error("not taken");
  property p_done; sp_we |-> done ##1 (!done && !busy); endproperty
  a_done: assert property (p_done) else $error("done late");
  property p_sp; sp_we |-> sp_wdata == sp_exp; endproperty
  a_sp: assert property (p_sp) else $error("bad pointer");
  property p_clr; reg_we && word_q |-> reg_wdata[19:16] == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("upper bits");
  property p_sr; sr_loaded |-> reg_we && reg_addr == SR_IDX; endproperty
  a_sr: assert property (p_sr) else $error("status load");
  property p_pre; op_valid && !busy && prefix_seen |=> !busy; endproperty
  a_pre: assert property (p_pre) else $error("prefix taken");
  property p_keep; push_q |-> !reg_we; endproperty
  a_keep: assert property (p_keep) else $error("push wrote reg");
  property p_wr; push_q && mem_req |-> mem_we; endproperty
  a_wr: assert property (p_wr) else $error("push read");
endmodule : mrs_top_checker
bind mrs_top mrs_top_checker chk_u (.clock, .rstn, .op_valid, .opcode, .prefix_seen, .sp_in,
  .busy, .done, .reg_addr, .reg_we, .reg_wdata, .sr_loaded, .sp_we, .sp_wdata, .mem_req,
  .mem_we);

//--- verification/mrs_top_tb.sv
// Self-checking bench for the stack transfer sequencer
`timescale 1ns/10ps
module mrs_top_tb;
  import mrs_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, op_valid = 1'b0, prefix_seen = 1'b0;
  logic [15:0] opcode = 16'h0000, mem_rdata, mem_wdata;
  logic [19:0] sp_in = 20'h08000, sp_got, reg_wdata, sp_wdata, mem_addr;
  logic busy, done, illegal, reg_we, sr_loaded, sp_we, mem_req, mem_we, mem_ready;
  logic [3:0] reg_addr;
  logic [19:0] regs [16];
  logic [24:0] wq [$];
  int err_total = 0, tests_run = 0, seed = 69;
  wire [19:0] reg_rdata = regs[reg_addr];
  always #5 clock = ~clock;
  mrs_top dut_u (.clock, .rstn, .op_valid, .opcode, .prefix_seen, .sp_in, .reg_rdata,
    .mem_ready, .mem_rdata, .busy, .done, .illegal, .reg_addr, .reg_we, .reg_wdata,
    .sr_loaded, .sp_we, .sp_wdata, .mem_req, .mem_we, .mem_addr, .mem_wdata);
  mrs_mem_model mem_u (.clock, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ready,
    .mem_rdata);
  // Register file writes and final pointer
  always @(posedge clock) begin
    if (reg_we) wq.push_back({sr_loaded, reg_addr, reg_wdata});
    if (reg_we) regs[reg_addr] <= reg_wdata;
    if (sp_we) sp_got <= sp_wdata;
  end
  task automatic check(input logic [24:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // One transfer against the stack model
  task automatic run(input bit push, word, input int n, dst);
    int st, t, r, a;
    logic [15:0] lo, hi;
    st = word ? 2 : 4;
    sp_in = 20'h08000 + 20'({$random(seed)} % 64 * 2);
    foreach (regs[i]) regs[i] = 20'($random(seed));
    for (a = -64; a < 66; a += 2) mem_u.mem[20'(sp_in + a)] = 16'($random(seed));
    wq.delete();
    opcode = {6'h05, !push, word, 4'(n - 1), 4'(dst)};
    op_valid = 1'b1;
    @(negedge clock);
    op_valid = 1'b0;
    for (t = 0; t < 400 && done !== 1'b1; t++) @(negedge clock);
    check(done, 1'b1);
    check(illegal, 1'b0);
    @(negedge clock);
    check(sp_got, 20'(push ? sp_in - st * n : sp_in + st * n));
    check(wq.size(), push ? 0 : n);
    for (int i = 0; i < n; i++) begin
      r = push ? dst - i : dst - n + 1 + i;
      a = push ? -st * (i + 1) : st * i;
      lo = mem_u.mem[20'(sp_in + a)];
      hi = mem_u.mem[20'(sp_in + a + 2)];
      if (push) check(word ? lo : {hi[3:0], lo}, word ? regs[r][15:0] : regs[r]);
      else check(wq[i], {r == SR_IDX, 4'(r), word ? {4'h0, lo} : {hi[3:0], lo}});
    end
  endtask : run
  task automatic final_report;
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // Main sequence: all forms, boundary counts, then a prefixed opcode
  initial begin
    int n;
    foreach (regs[i]) regs[i] = 20'h00000;
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    for (int k = 0; k < 12; k++) begin
      n = k < 4 ? 16 : k < 8 ? 1 : 1 + {$random(seed)} % 16;
      run(k[0], k[1], n, k < 4 ? 15 : n - 1 + {$random(seed)} % (17 - n));
    end
    prefix_seen = 1'b1;
    op_valid = 1'b1;
    repeat (3) @(negedge clock);
    check(busy | mem_req, 1'b0);
    check(illegal, 1'b1);
    op_valid = 1'b0;
    prefix_seen = 1'b0;
    final_report();
  end
  // Watchdog
  initial begin
    #100000;
    err_total++;
    final_report();
  end
endmodule : mrs_top_tb
